// File: hw/drc_top.sv
// Serial command decoder for software full reset, range-change reset and no-op frames
`timescale 1ns/1ps

module drc_top
	import drc_pkg::*;
(
	// Clock, reset, enable
	input  wire logic        clk_sys_in,
	input  wire logic        reset_n_in,
	input  wire logic        clk_en_in,
	// Serial port pins
	input  wire logic        sclk_in,
	input  wire logic        sync_n_in,
	input  wire logic        sdi_in,
	// Device state
	output logic             clamp_analog_ground_out,
	output logic             buffer_power_out,
	output logic [2:0]       range_out,
	output logic [15:0]      ctrl_word_out,
	output logic             full_reset_pulse_out
);

	// ****************************************
	// Reset release and pin synchronisers
	// ****************************************
	logic [1:0] rst_sync_q;
	logic       rst_n;
	logic       sclk_syn;
	logic       sync_n_syn;
	logic       sdi_syn;
	logic       sclk_last_q;

	always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rst_sync_q <= 2'h0;
		end else if (clk_en_in) begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_q[1];

	// Serial clock and frame select idle high between frames
	drc_sync2 #(
		.RST_VAL (1'b1)
	) u_sclk_sync (
		.clk_in   (clk_sys_in),
		.rst_n_in (rst_n),
		.en_in    (clk_en_in),
		.d_in     (sclk_in),
		.q_out    (sclk_syn)
	);

	drc_sync2 #(
		.RST_VAL (1'b1)
	) u_sync_n_sync (
		.clk_in   (clk_sys_in),
		.rst_n_in (rst_n),
		.en_in    (clk_en_in),
		.d_in     (sync_n_in),
		.q_out    (sync_n_syn)
	);

	drc_sync2 #(
		.RST_VAL (1'b0)
	) u_sdi_sync (
		.clk_in   (clk_sys_in),
		.rst_n_in (rst_n),
		.en_in    (clk_en_in),
		.d_in     (sdi_in),
		.q_out    (sdi_syn)
	);

	// Edge history starts at the idle level so reset gives no false edge
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			sclk_last_q <= 1'b1;
		end else if (clk_en_in) begin
			sclk_last_q <= sclk_syn;
		end
	end

	// ****************************************
	// Frame shifter
	// ****************************************
	wire sclk_fall  = sclk_last_q & ~sclk_syn;
	wire frame_act  = ~sync_n_syn;

	drc_state_e            state_q, state_d;
	logic [FRAME_BITS-1:0] shift_q, shift_d;
	logic [CNT_W-1:0]      cnt_q, cnt_d;

	// Bits taken on falling SCLK, MSB first
	wire in_shift   = (state_q == DRC_SHIFT);
	wire bit_take   = frame_act & sclk_fall;
	wire frame_done = bit_take & in_shift & (cnt_q == FRAME_LAST);

	always_comb begin
		state_d = state_q;
		shift_d = shift_q;
		cnt_d   = cnt_q;
		case (state_q)
			DRC_IDLE: begin
				cnt_d = '0;
				if (frame_act) begin
					state_d = DRC_SHIFT;
				end
			end
			DRC_SHIFT: begin
				if (!frame_act) begin
					// Partial frame dropped
					state_d = DRC_IDLE;
				end else if (bit_take) begin
					shift_d = {shift_q[FRAME_BITS-2:0], sdi_syn};
					cnt_d   = cnt_q + 5'h01;
					if (frame_done) begin
						state_d = DRC_DECODE;
					end
				end
			end
			DRC_DECODE: begin
				// Wait for frame end before accepting another
				if (!frame_act) begin
					state_d = DRC_IDLE;
				end
			end
			default: state_d = DRC_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= DRC_IDLE;
			shift_q <= '0;
			cnt_q   <= '0;
		end else if (clk_en_in) begin
			state_q <= state_d;
			shift_q <= shift_d;
			cnt_q   <= cnt_d;
		end
	end

	// ****************************************
	// Command decode
	// ****************************************
	drc_frame_s frame;
	logic       cmd_go_q;

	assign frame.addr = shift_q[ADDR_HI:ADDR_LO];
	assign frame.data = shift_q[DATA_HI:0];

	// Decode in the cycle after the last bit is taken, the cycle in which it lands in the shifter
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			cmd_go_q <= 1'b0;
		end else if (clk_en_in) begin
			cmd_go_q <= frame_done;
		end
	end

	wire is_nop = (frame.addr == ADDR_NOP0) | (frame.addr == ADDR_NOP5) | (frame.addr == ADDR_NOP6)
	            | (frame.addr == ADDR_NOPD) | (frame.addr == ADDR_NOPE);
	wire is_full_rst = cmd_go_q & (frame.addr == ADDR_FULL_RST);
	wire is_ctrl_wr  = cmd_go_q & ~is_nop & (frame.addr == ADDR_CTRL_WR);
	wire [2:0] new_range = frame.data[RANGE_LO+2:RANGE_LO];
	wire range_chg   = is_ctrl_wr & ~clamp_analog_ground_out & (new_range != range_out);
	wire do_reset    = is_full_rst | range_chg;

	// ****************************************
	// Device state
	// ****************************************
	always_ff @(posedge clk_sys_in or negedge rst_n) begin
		if (!rst_n) begin
			clamp_analog_ground_out <= 1'b1;
			buffer_power_out        <= 1'b0;
			range_out               <= RANGE_RST;
			ctrl_word_out           <= CTRL_RST;
			full_reset_pulse_out    <= 1'b0;
		end else if (clk_en_in) begin
			full_reset_pulse_out <= do_reset;
			if (do_reset) begin
				// Power-up state: clamp on, buffer off
				clamp_analog_ground_out <= 1'b1;
				buffer_power_out        <= 1'b0;
				ctrl_word_out           <= CTRL_RST;
				range_out               <= range_chg ? new_range : RANGE_RST;
			end else if (is_ctrl_wr) begin
				// Control write sets clamp from the inverse of CLAMP_OFF_BIT and buffer from BUF_ON_BIT
				clamp_analog_ground_out <= ~frame.data[CLAMP_OFF_BIT];
				buffer_power_out        <= frame.data[BUF_ON_BIT];
				ctrl_word_out           <= frame.data;
				range_out               <= new_range;
			end
		end
	end

endmodule

// ****************************************
// Two-flop synchroniser for one pin
// ****************************************
module drc_sync2
	import drc_pkg::*;
#(
	parameter logic RST_VAL = 1'b0
) (
	// Clock, reset, enable
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	input  wire logic en_in,
	// Pin and its synchronised copy
	input  wire logic d_in,
	output logic      q_out
);

	logic [1:0] sync_q;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sync_q <= {2{RST_VAL}};
		end else if (en_in) begin
			sync_q <= {sync_q[0], d_in};
		end
	end
	assign q_out = sync_q[1];

endmodule

// File: hw/drc_pkg.sv
// Package: command codes, frame layout and reset values for the reset/no-op decoder
package drc_pkg;

	// ****************************************
	// Frame layout
	// ****************************************
	localparam int unsigned FRAME_BITS = 24;
	localparam int unsigned ADDR_HI    = 19;
	localparam int unsigned ADDR_LO    = 16;
	localparam int unsigned DATA_HI    = 15;
	localparam int unsigned CNT_W      = 5;
	localparam logic [4:0]  FRAME_LAST = 5'h17;

	// ****************************************
	// Register address codes
	// ****************************************
	localparam logic [3:0] ADDR_NOP0      = 4'h0;
	localparam logic [3:0] ADDR_NOP5      = 4'h5;
	localparam logic [3:0] ADDR_NOP6      = 4'h6;
	localparam logic [3:0] ADDR_NOPD      = 4'hd;
	localparam logic [3:0] ADDR_NOPE      = 4'he;
	localparam logic [3:0] ADDR_FULL_RST  = 4'hf;
	localparam logic [3:0] ADDR_CTRL_WR   = 4'h4;

	// ****************************************
	// Control word field positions and reset values
	// ****************************************
	localparam int unsigned RANGE_LO      = 0;
	localparam int unsigned CLAMP_OFF_BIT = 5;
	localparam int unsigned BUF_ON_BIT    = 6;
	localparam logic [2:0]  RANGE_RST     = 3'h0;
	localparam logic [15:0] CTRL_RST      = 16'h0000;

	// Decoded frame handed to the state logic
	typedef struct packed {
		logic [3:0]  addr;
		logic [15:0] data;
	} drc_frame_s;

	typedef enum logic [1:0] {
		DRC_IDLE   = 2'b00,
		DRC_SHIFT  = 2'b01,
		DRC_DECODE = 2'b10
	} drc_state_e;

endpackage

// File: tb/drc_monitor.sv
// Checker on the decoder's ports
`timescale 1ns/1ps
module drc_monitor
	import drc_pkg::*;
(
	// Clock, reset, frame select
	input wire logic        clk_sys_in,
	input wire logic        reset_n_in,
	input wire logic        sync_n_in,
	// Device state
	input wire logic        clamp_analog_ground_out,
	input wire logic        buffer_power_out,
	input wire logic [2:0]  range_out,
	input wire logic [15:0] ctrl_word_out,
	input wire logic        full_reset_pulse_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!reset_n_in);
	sequence s_idle; sync_n_in[*8]; endsequence
	sequence s_pulse; full_reset_pulse_out ##1 !full_reset_pulse_out; endsequence
	property p_vals;
		full_reset_pulse_out |-> clamp_analog_ground_out && !buffer_power_out && ctrl_word_out == CTRL_RST;
	endproperty
	a_vals: assert property (p_vals) else $error("bad reset state");
	property p_len; full_reset_pulse_out |-> s_pulse; endproperty
	a_len: assert property (p_len) else $error("long pulse");
	property p_clamp; clamp_analog_ground_out == !ctrl_word_out[CLAMP_OFF_BIT]; endproperty
	a_clamp: assert property (p_clamp) else $error("bad clamp");
	property p_buf; buffer_power_out == ctrl_word_out[BUF_ON_BIT]; endproperty
	a_buf: assert property (p_buf) else $error("bad buffer");
	property p_range; $changed(range_out) && !$past(clamp_analog_ground_out) |-> full_reset_pulse_out; endproperty
	a_range: assert property (p_range) else $error("no range reset");
	property p_quiet; s_idle |=> $stable(ctrl_word_out) && $stable(range_out) && !full_reset_pulse_out; endproperty
	a_quiet: assert property (p_quiet) else $error("change outside frame");
	property p_framed; full_reset_pulse_out |-> !$past(sync_n_in, 8); endproperty
	a_framed: assert property (p_framed) else $error("pulse without frame");
endmodule
bind drc_top drc_monitor mon (.clk_sys_in, .reset_n_in, .sync_n_in, .clamp_analog_ground_out, .buffer_power_out,
	.range_out, .ctrl_word_out, .full_reset_pulse_out);

// File: tb/drc_host.sv
// Host serial port model
`timescale 1ns/1ps
module drc_host (
	// Clock
	input  wire logic clk_in,
	// Serial pins
	output logic      sclk_out,
	output logic      sync_n_out,
	output logic      sdi_out
);
	initial begin
		sclk_out = 1'b1;
		sync_n_out = 1'b1;
		sdi_out = 1'b0;
	end
	// Shifts the top n bits MSB first; the clock stands high between frames
	task automatic send(input logic [23:0] w, input int n);
		@(negedge clk_in) sync_n_out = 1'b0;
		for (int i = 23; i > 23 - n; i--) begin
			sdi_out = w[i];
			repeat (4) @(negedge clk_in);
			sclk_out = 1'b0;
			repeat (4) @(negedge clk_in);
			sclk_out = 1'b1;
		end
		repeat (4) @(negedge clk_in);
		sync_n_out = 1'b1;
		sdi_out = ~sdi_out;
		repeat (16) @(negedge clk_in);
	endtask
endmodule

// File: tb/test_drc_top.sv
// Self-checking bench for the reset and no-op decoder
`timescale 1ns/1ps
module test_drc_top import drc_pkg::*;;
	logic        clk, rst_n, sclk, sync_n, sdi, clamp, bon, pulse;
	logic [2:0]  range;
	logic [15:0] ctrl;
	logic [3:0]  pulses = 4'h0;
	int          bad_count = 0;
	int          cmp_count = 0;
	int          cycles = 0;
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		rst_n = 1'b0;
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
	end
	drc_top dut (.clk_sys_in(clk), .reset_n_in(rst_n), .clk_en_in(1'b1), .sclk_in(sclk), .sync_n_in(sync_n),
		.sdi_in(sdi), .clamp_analog_ground_out(clamp), .buffer_power_out(bon), .range_out(range),
		.ctrl_word_out(ctrl), .full_reset_pulse_out(pulse));
	drc_host host (.clk_in(clk), .sclk_out(sclk), .sync_n_out(sync_n), .sdi_out(sdi));
	always @(negedge clk) begin
		cycles++;
		if (pulse === 1'b1)
			pulses++;
		if (cycles == 12000) begin
			bad_count++;
			give_verdict();
		end
	end
	task automatic chk(input logic [24:0] exp);
		cmp_count++;
		if ({pulses, clamp, bon, range, ctrl} !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, {pulses, clamp, bon, range, ctrl}, exp);
		end
	endtask
	task automatic t_power_up();
		chk({4'h0, 1'b1, 1'b0, RANGE_RST, CTRL_RST});
	endtask
	task automatic t_config();
		host.send({4'h0, ADDR_CTRL_WR, 16'h0063}, 24);
		chk({4'h0, 1'b0, 1'b1, 3'h3, 16'h0063});
	endtask
	task automatic t_noop();
		logic [3:0] nop [5] = '{ADDR_NOP0, ADDR_NOP5, ADDR_NOP6, ADDR_NOPD, ADDR_NOPE};
		foreach (nop[i]) begin
			host.send({4'h0, nop[i], 16'hffff}, 24);
			chk({4'h0, 1'b0, 1'b1, 3'h3, 16'h0063});
		end
	endtask
	task automatic t_partial();
		host.send({4'h0, ADDR_FULL_RST, 16'h0000}, 12);
		chk({4'h0, 1'b0, 1'b1, 3'h3, 16'h0063});
	endtask
	task automatic t_full();
		host.send({4'h0, ADDR_FULL_RST, 16'h1234}, 24);
		chk({4'h1, 1'b1, 1'b0, RANGE_RST, CTRL_RST});
	endtask
	task automatic t_range();
		host.send({4'h0, ADDR_CTRL_WR, 16'h0063}, 24);
		host.send({4'h0, ADDR_CTRL_WR, 16'h0065}, 24);
		chk({4'h2, 1'b1, 1'b0, 3'h5, CTRL_RST});
	endtask
	task automatic give_verdict();
		if (bad_count == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		@(posedge rst_n);
		repeat (4) @(negedge clk);
		t_power_up();
		t_config();
		t_noop();
		t_partial();
		t_full();
		t_range();
		give_verdict();
	end
endmodule
